// File: logic/aecsq_regs.sv
// Exposure loop status and sequencer main control registers behind an AHB-Lite slave
`default_nettype none
module aecsq_regs (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire aecsq_pkg::aecsq_aec_t aec,
    input wire logic row_transfer_phase_end,
    output aecsq_pkg::aecsq_mode_t mode,
    output logic readout_start,
    output logic irq
);
    logic [15:0] ctrl;
    logic [15:0] delay_cfg;
    logic [18:0] pix_q;
    logic [9:0] mean_q;
    logic lock_q;
    logic [15:0] expo_q;
    aecsq_pkg::aecsq_gain_t gain_q;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [2:0] events;
    logic [2:0] w1c;
    logic wr_pend;
    logic rd_pend;
    logic [7:0] dp_index;
    logic addr_hit;
    logic take;
    logic gap_start;
    logic gap_done;
    logic gap_busy;
    logic lock_prev;
    logic [15:0] next_rdata;

    // Address phase accepted only with hready high and a non-sequential transfer
    assign take = hsel && hready && (htrans == aecsq_pkg::HTRANS_NONSEQ);
    assign addr_hit = (haddr[31:aecsq_pkg::ADDR_TOP_LSB] == 22'h000000);

    // Latch the address phase; reads cost one wait state so hrdata can be registered
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_index <= 8'h00;
        end else begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
            dp_index <= addr_hit ? aecsq_pkg::reg_index(haddr) : 8'hff;
        end
    end

    // Wait state only on the first data cycle of a read
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hreadyout <= 1'b1;
            hresp <= aecsq_pkg::HRESP_OKAY;
        end else begin
            hreadyout <= !(take && !hwrite);
            hresp <= aecsq_pkg::HRESP_OKAY;
        end
    end

    // Read multiplexer; unmapped and reserved words read as zero
    always_comb begin
        next_rdata = 16'h0000;
        unique case (dp_index)
            aecsq_pkg::IDX_PIX_LO: next_rdata = pix_q[aecsq_pkg::PIX_LO_MSB:0];
            aecsq_pkg::IDX_PIX_HI: next_rdata = {13'h0000, pix_q[aecsq_pkg::PIX_MSB:aecsq_pkg::PIX_HI_LSB]};
            aecsq_pkg::IDX_MEAN_LOCK: next_rdata = {3'h0, lock_q, 2'h0, mean_q};
            aecsq_pkg::IDX_INTEG: next_rdata = expo_q;
            aecsq_pkg::IDX_AMPL: next_rdata = gain_q;
            aecsq_pkg::IDX_CTRL: next_rdata = ctrl;
            aecsq_pkg::IDX_DELAY: next_rdata = delay_cfg;
            aecsq_pkg::IDX_IRQ_STATUS: next_rdata = {13'h0000, irq_status};
            aecsq_pkg::IDX_IRQ_MASK: next_rdata = {13'h0000, irq_mask};
            default: next_rdata = 16'h0000;
        endcase
    end

    // Read data registered during the wait state
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hrdata <= 32'h00000000;
        end else if (rd_pend) begin
            hrdata <= {16'h0000, next_rdata};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ctrl <= aecsq_pkg::CTRL_RESET;
        end else if (wr_pend && dp_index == aecsq_pkg::IDX_CTRL) begin
            ctrl <= hwdata[15:0] & aecsq_pkg::CTRL_WMASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            delay_cfg <= aecsq_pkg::DELAY_RESET;
        end else if (wr_pend && dp_index == aecsq_pkg::IDX_DELAY) begin
            delay_cfg <= hwdata[15:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pix_q <= 19'h00000;
        end else begin
            pix_q <= aec.pixel_count;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mean_q <= 10'h000;
            lock_q <= 1'b0;
            lock_prev <= 1'b0;
        end else begin
            mean_q <= aec.mean;
            lock_q <= aec.locked;
            lock_prev <= lock_q;
        end
    end

    // exposure taken only when the loop announces a change
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            expo_q <= aecsq_pkg::STATUS_RESET;
        end else if (aec.exposure_update) begin
            expo_q <= aec.exposure;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            gain_q <= aecsq_pkg::STATUS_RESET;
        end else begin
            gain_q <= aec.gain;
        end
    end

    // trigger and follower forced off in rolling shutter
    // subsample and binning straight from the control word
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mode <= '0;
        end else begin
            mode.enable <= ctrl[aecsq_pkg::CTRL_ENABLE];
            mode.rolling <= ctrl[aecsq_pkg::CTRL_ROLLING];
            mode.triggered <= ctrl[aecsq_pkg::CTRL_TRIGGERED] && !ctrl[aecsq_pkg::CTRL_ROLLING];
            mode.follower <= ctrl[aecsq_pkg::CTRL_FOLLOWER] && !ctrl[aecsq_pkg::CTRL_ROLLING];
            mode.subsample <= ctrl[aecsq_pkg::CTRL_SUBSAMPLE];
            mode.binning <= ctrl[aecsq_pkg::CTRL_BINNING];
        end
    end

    // gap timer runs only when the gap bit is set
    assign gap_start = row_transfer_phase_end && ctrl[aecsq_pkg::CTRL_GAP_EN];

    aecsq_gap_timer u_gap (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .start(gap_start),
        .length(delay_cfg[15:aecsq_pkg::DELAY_GAP_LSB]),
        .done(gap_done),
        .busy(gap_busy)
    );

    // readout starts a cycle after the end of row transfer or after the gap
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            readout_start <= 1'b0;
        end else begin
            readout_start <= gap_done || (row_transfer_phase_end && !ctrl[aecsq_pkg::CTRL_GAP_EN]);
        end
    end

    // Events: lock gained, exposure changed, readout gap finished
    // The lock event uses the captured flag so that it agrees with the status word
    assign events = {gap_done, aec.exposure_update, lock_q && !lock_prev};
    assign w1c = (wr_pend && dp_index == aecsq_pkg::IDX_IRQ_STATUS) ? hwdata[2:0] : 3'h0;

    // Sticky status; an event in the clearing cycle wins over the clear
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq_status <= aecsq_pkg::IRQ_RESET;
        end else begin
            irq_status <= (irq_status & ~w1c) | events;
        end
    end

    // Interrupt mask
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq_mask <= aecsq_pkg::IRQ_RESET;
        end else if (wr_pend && dp_index == aecsq_pkg::IDX_IRQ_MASK) begin
            irq_mask <= hwdata[2:0];
        end
    end

    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // Status capture checks: pixel count, mean, lock and digital gain follow the loop one cycle behind; exposure only on an update
    chk_pix_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> pix_q == $past(aec.pixel_count))
        else $error("pixel count not captured");
    chk_mean_lock: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 1'b1 |-> (mean_q == $past(aec.mean)) && (lock_q == $past(aec.locked)))
        else $error("mean or lock not captured");
    chk_gain_fields: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> gain_q.digital_gain == $past(aec.gain.digital_gain))
        else $error("digital gain field wrong");
    chk_expo_update: assert property (@(posedge ref_clk) disable iff (!nrst)
        !aec.exposure_update |=> $stable(expo_q))
        else $error("exposure status moved without update");
    chk_expo_take: assert property (@(posedge ref_clk) disable iff (!nrst)
        aec.exposure_update |=> expo_q == $past(aec.exposure))
        else $error("exposure update not taken");

    // Mode output checks; the outputs trail the control word by one cycle
    chk_mode_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> mode.enable == $past(ctrl[0]) && mode.rolling == $past(ctrl[1]))
        else $error("enable or shutter output wrong");
    chk_ctrl_reserved: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |-> (ctrl & ~aecsq_pkg::CTRL_WMASK) == 16'h0000)
        else $error("reserved control bit set");
    chk_global_only: assert property (@(posedge ref_clk) disable iff (!nrst)
        (mode.triggered || mode.follower) |-> !mode.rolling)
        else $error("trigger or follower active in rolling shutter");
    chk_mode_bits: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 1'b1 |-> mode.subsample == $past(ctrl[7]) && mode.binning == $past(ctrl[8]))
        else $error("subsample or binning output wrong");

    // Readout gap checks; a restart inside the window would move the end, so it is excluded
    chk_gap_bypass: assert property (@(posedge ref_clk) disable iff (!nrst)
        row_transfer_phase_end && !ctrl[6] && !gap_busy && !gap_done |=> readout_start)
        else $error("readout not started after row transfer");
    chk_gap_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
        row_transfer_phase_end && ctrl[6] && !gap_done |=> !readout_start)
        else $error("readout started without the gap");
    chk_gap_short: assert property (@(posedge ref_clk) disable iff (!nrst)
        gap_start && delay_cfg[15:8] <= 8'h01 |=> gap_done)
        else $error("short gap not ended after one cycle");
    chk_gap_three: assert property (@(posedge ref_clk) disable iff (!nrst)
        gap_start && delay_cfg[15:8] == 8'h03 ##1 !gap_start [*2] |=> gap_done)
        else $error("gap of three cycles not honoured");
    chk_gap_length: assert property (@(posedge ref_clk) disable iff (!nrst)
        gap_start && delay_cfg[15:8] == 8'h04 ##1 !gap_start [*4] |=> readout_start && !$past(readout_start))
        else $error("gap of four cycles not honoured");

    // Interrupt checks; a new event must survive a clear in the same cycle
    chk_set_wins: assert property (@(posedge ref_clk) disable iff (!nrst)
        events[1] |=> irq_status[1])
        else $error("exposure event lost");
    chk_w1c_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        w1c[1] && !events[1] |=> !irq_status[1])
        else $error("status bit not cleared");
    chk_irq_level: assert property (@(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> irq == $past(|(irq_status & irq_mask)))
        else $error("interrupt level wrong");

    // Bus timing checks; reads carry exactly one wait state, writes none
    chk_read_wait: assert property (@(posedge ref_clk) disable iff (!nrst)
        take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_ready: assert property (@(posedge ref_clk) disable iff (!nrst)
        take && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    chk_rdata_stand: assert property (@(posedge ref_clk) disable iff (!nrst)
        !rd_pend |=> $stable(hrdata))
        else $error("read data moved without a read");
endmodule : aecsq_regs
`default_nettype wire

// File: logic/aecsq_pkg.sv
// Package: register map, field layout and shared types of the exposure status and sequencer control bank
`default_nettype none
package aecsq_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PIX_LO = 8'hb8;
    localparam logic [7:0] IDX_PIX_HI = 8'hb9;
    localparam logic [7:0] IDX_MEAN_LOCK = 8'hba;
    localparam logic [7:0] IDX_INTEG = 8'hbb;
    localparam logic [7:0] IDX_AMPL = 8'hbc;
    localparam logic [7:0] IDX_SPARE = 8'hbd;
    localparam logic [7:0] IDX_CTRL = 8'hc0;
    localparam logic [7:0] IDX_DELAY = 8'hc1;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'he0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'he1;
    // Upper address bits that must be zero for a hit
    localparam int ADDR_TOP_LSB = 10;
    // Field positions
    localparam int PIX_LO_MSB = 15;
    localparam int PIX_HI_LSB = 16;
    localparam int PIX_MSB = 18;
    localparam int MEAN_MSB = 9;
    localparam int LOCK_BIT = 12;
    localparam int AGAIN1_LSB = 0;
    localparam int AGAIN2_LSB = 2;
    localparam int DGAIN_LSB = 4;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_ROLLING = 1;
    localparam int CTRL_TRIGGERED = 4;
    localparam int CTRL_FOLLOWER = 5;
    localparam int CTRL_GAP_EN = 6;
    localparam int CTRL_SUBSAMPLE = 7;
    localparam int CTRL_BINNING = 8;
    localparam int DELAY_GAP_LSB = 8;
    // Writable bits of the control word; reserved bits stay zero
    localparam logic [15:0] CTRL_WMASK = 16'h01f3;
    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] DELAY_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // Interrupt event bits
    localparam int EV_LOCK = 0;
    localparam int EV_EXPO = 1;
    localparam int EV_GAP = 2;
    localparam int EV_COUNT = 3;
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // Gain as chosen by the exposure loop
    typedef struct packed {
        logic [11:0] digital_gain;
        logic [1:0] analog_gain_second_step;
        logic [1:0] analog_gain_first_step;
    } aecsq_gain_t;

    // Results of the exposure loop, all on ref_clk
    typedef struct packed {
        logic [18:0] pixel_count;
        logic [9:0] mean;
        logic locked;
        logic [15:0] exposure;
        logic exposure_update;
        aecsq_gain_t gain;
    } aecsq_aec_t;

    // Sequencer mode outputs
    typedef struct packed {
        logic enable;
        logic rolling;
        logic triggered;
        logic follower;
        logic subsample;
        logic binning;
    } aecsq_mode_t;

    // Register index from a byte address
    function automatic logic [7:0] reg_index(input logic [31:0] addr);
        reg_index = addr[9:2];
    endfunction : reg_index
endpackage : aecsq_pkg
`default_nettype wire

// File: logic/aecsq_gap_timer.sv
// Readout gap timer: counts the programmed gap after the end of row transfer
`default_nettype none
module aecsq_gap_timer (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic [7:0] length,
    output logic done,
    output logic busy
);
    logic [7:0] count;

    // Down counter; a length of zero still takes one cycle
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            count <= 8'h00;
            done <= 1'b0;
        end else if (start) begin
            // Lengths of zero and one both end after one cycle; longer ones load one less
            count <= (length > 8'h01) ? length - 8'h01 : 8'h00;
            done <= (length <= 8'h01);
        end else if (count > 8'h01) begin
            count <= count - 8'h01;
            done <= 1'b0;
        end else begin
            done <= (count == 8'h01);
            count <= 8'h00;
        end
    end

    assign busy = (count != 8'h00);
endmodule : aecsq_gap_timer
`default_nettype wire

// File: sim/testbench.sv
// Self-checking testbench for the exposure status and sequencer control register bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk;
    logic nrst;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic [31:0] hrdata;
    logic hresp;
    aecsq_pkg::aecsq_aec_t aec;
    logic row_transfer_phase_end;
    aecsq_pkg::aecsq_mode_t mode;
    logic readout_start;
    logic irq;
    int n_errors = 0;
    int n_compared = 0;
    logic [31:0] rd;

    aecsq_regs uut (
        .ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .aec(aec), .row_transfer_phase_end(row_transfer_phase_end), .mode(mode),
        .readout_start(readout_start), .irq(irq)
    );

    // Free-running 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
        n_compared++;
        if (seen !== expected) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", name, expected, seen);
        end
    endtask : check

    task automatic summarize();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // One single AHB-Lite word transfer; entered right after a rising edge
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wdata, output logic [31:0] rdata);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= aecsq_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rdata = hrdata;
        check("hresp", {31'h0, hresp}, {31'h0, aecsq_pkg::HRESP_OKAY});
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [31:0] data);
        logic [31:0] dummy;
        bus(idx, 1'b1, data, dummy);
    endtask : wr

    task automatic rd_check(input string name, input logic [7:0] idx, input logic [31:0] expected);
        logic [31:0] v;
        bus(idx, 1'b0, 32'h0, v);
        check(name, v, expected);
    endtask : rd_check

    // Status, spare and control words read their reset values; delay and interrupt registers are not read
    task automatic test_reset_values();
        rd_check("pix_lo rst", aecsq_pkg::IDX_PIX_LO, 32'h0);
        rd_check("pix_hi rst", aecsq_pkg::IDX_PIX_HI, 32'h0);
        rd_check("mean rst", aecsq_pkg::IDX_MEAN_LOCK, 32'h0);
        rd_check("integ rst", aecsq_pkg::IDX_INTEG, 32'h0);
        rd_check("ampl rst", aecsq_pkg::IDX_AMPL, 32'h0);
        rd_check("spare rst", aecsq_pkg::IDX_SPARE, 32'h0);
        rd_check("ctrl rst", aecsq_pkg::IDX_CTRL, 32'h0);
        check("mode rst", {26'h0, mode}, 32'h0);
    endtask : test_reset_values

    // Loop results reach the status words, read-only places ignore writes
    task automatic test_status();
        aec.pixel_count <= 19'h5a5a5;
        aec.mean <= 10'h2c3;
        aec.locked <= 1'b1;
        aec.gain <= '{digital_gain: 12'hab5, analog_gain_second_step: 2'h2, analog_gain_first_step: 2'h1};
        aec.exposure <= 16'h1234;
        @(posedge ref_clk);
        rd_check("pix_lo", aecsq_pkg::IDX_PIX_LO, 32'h0000a5a5);
        rd_check("pix_hi", aecsq_pkg::IDX_PIX_HI, 32'h00000005);
        rd_check("mean_lock", aecsq_pkg::IDX_MEAN_LOCK, 32'h000012c3);
        rd_check("ampl", aecsq_pkg::IDX_AMPL, 32'h0000ab59);
        rd_check("integ no update", aecsq_pkg::IDX_INTEG, 32'h0);
        aec.exposure_update <= 1'b1;
        @(posedge ref_clk);
        aec.exposure_update <= 1'b0;
        aec.exposure <= 16'h4321;
        @(posedge ref_clk);
        rd_check("integ update", aecsq_pkg::IDX_INTEG, 32'h00001234);
        wr(aecsq_pkg::IDX_PIX_LO, 32'hffffffff);
        wr(aecsq_pkg::IDX_SPARE, 32'hffffffff);
        rd_check("pix_lo ro", aecsq_pkg::IDX_PIX_LO, 32'h0000a5a5);
        rd_check("spare", aecsq_pkg::IDX_SPARE, 32'h0);
        rd_check("unmapped", 8'h50, 32'h0);
    endtask : test_status

    // Control bits map onto the mode outputs; global-only modes drop under rolling shutter
    task automatic test_control();
        wr(aecsq_pkg::IDX_CTRL, 32'h0000ffff);
        rd_check("ctrl mask", aecsq_pkg::IDX_CTRL, 32'h000001f3);
        check("mode rolling", {26'h0, mode}, {26'h0, 6'b110011});
        wr(aecsq_pkg::IDX_CTRL, 32'h000001b1);
        repeat (2) @(posedge ref_clk);
        check("mode global", {26'h0, mode}, {26'h0, 6'b101111});
        wr(aecsq_pkg::IDX_CTRL, 32'h00000080);
        repeat (2) @(posedge ref_clk);
        check("mode subsample", {26'h0, mode}, {26'h0, 6'b000010});
        wr(aecsq_pkg::IDX_CTRL, 32'h00000100);
        repeat (2) @(posedge ref_clk);
        check("mode binning", {26'h0, mode}, {26'h0, 6'b000001});
        wr(aecsq_pkg::IDX_CTRL, 32'h00000001);
        repeat (2) @(posedge ref_clk);
        check("mode enable", {26'h0, mode}, {26'h0, 6'b100000});
    endtask : test_control

    // Pulses end of row transfer and reports the cycle of the first readout start
    task automatic gap_run(input string name, input int expected);
        int first;
        int highs;
        first = 0;
        highs = 0;
        row_transfer_phase_end <= 1'b1;
        for (int k = 1; k <= 12; k++) begin
            @(posedge ref_clk);
            row_transfer_phase_end <= 1'b0;
            #1;
            if (readout_start === 1'b1) begin
                highs++;
                if (first == 0) first = k;
            end
        end
        @(posedge ref_clk);
        check(name, first, expected);
        check("readout pulse", highs, 1);
    endtask : gap_run

    // Readout gap off, programmed length, and the zero-length boundary
    task automatic test_gap();
        wr(aecsq_pkg::IDX_DELAY, 32'h000003a5);
        rd_check("delay cfg", aecsq_pkg::IDX_DELAY, 32'h000003a5);
        gap_run("no gap", 1);
        wr(aecsq_pkg::IDX_CTRL, 32'h00000040);
        gap_run("gap 3", 4);
        wr(aecsq_pkg::IDX_DELAY, 32'h000000a5);
        gap_run("gap 0", 2);
        wr(aecsq_pkg::IDX_DELAY, 32'h000001a5);
        gap_run("gap 1", 2);
        wr(aecsq_pkg::IDX_DELAY, 32'h00000400);
        gap_run("gap 4", 5);
    endtask : test_gap

    // Sticky events, masking and write-one-to-clear of the interrupt
    task automatic test_irq();
        rd_check("irq status", aecsq_pkg::IDX_IRQ_STATUS, 32'h7);
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(aecsq_pkg::IDX_IRQ_MASK, 32'h2);
        repeat (3) @(posedge ref_clk);
        check("irq raised", {31'h0, irq}, 32'h1);
        wr(aecsq_pkg::IDX_IRQ_STATUS, 32'h2);
        rd_check("irq w1c", aecsq_pkg::IDX_IRQ_STATUS, 32'h5);
        check("irq cleared", {31'h0, irq}, 32'h0);
        wr(aecsq_pkg::IDX_IRQ_MASK, 32'h5);
        repeat (3) @(posedge ref_clk);
        check("irq other", {31'h0, irq}, 32'h1);
        rd_check("irq mask", aecsq_pkg::IDX_IRQ_MASK, 32'h5);
        wr(aecsq_pkg::IDX_IRQ_STATUS, 32'h5);
        repeat (3) @(posedge ref_clk);
        check("irq all clear", {31'h0, irq}, 32'h0);
    endtask : test_irq

    // Main sequence
    initial begin
        nrst = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        aec = '0;
        row_transfer_phase_end = 1'b0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        test_reset_values();
        test_status();
        test_control();
        test_gap();
        test_irq();
        summarize();
    end

    // Watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        summarize();
    end
endmodule : testbench
`default_nettype wire
